// ### verilog/otx_consts.svh
// constants of the optical transmit control and signal-detect block
// assumes: included by the package and the design; 32-bit AXI4-Lite word map
//
// What this block does
// R1 - disable input high turns every laser off; low allows transmission.
// R2 - enable input low keeps lasers off; transmission only while high.
// R3 - undriven disable reads low; undriven enable and reset read high.
// R4 - fault raised by laser over-current, over-temperature or calibration corruption.
// R5 - active-low fault output high in normal operation, low during fault.
// R6 - fault latches and keeps lasers off until cleared by reset input.
// R7 - reset input low resets transmit logic, lasers off; high restores operation.
// R8 - signal-detect high only when all four receive lanes see light.
// R9 - any single lane losing signal drives signal-detect low.
// R10 - receive data outputs squelched while signal-detect is low.
// R11 - disable is complement of enable; cycling enable also clears fault.
// R12 - lasers emit only with enable, no disable, reset high, no fault.
`ifndef OTX_CONSTS_SVH
`define OTX_CONSTS_SVH

`define OTX_LANES        4
`define OTX_ADDR_W       4
`define OTX_OFF_CTRL     4'h0
`define OTX_OFF_STATUS   4'h4
`define OTX_OFF_EVENT    4'h8
`define OTX_OFF_MASK     4'hC
// control register fields
`define OTX_CTRL_LASER_OFF  0
`define OTX_CTRL_FAULT_CLR  1
// event and mask register fields
`define OTX_EV_FAULT     0
`define OTX_EV_LOS       1
`define OTX_EV_GAIN      2
`define OTX_EV_W         3
`define OTX_CTRL_RST     2'h0
`define OTX_MASK_RST     3'h0
// pin levels seen when the host leaves a pin undriven
`define OTX_PULL_DISABLE 1'b0
`define OTX_PULL_ENABLE  1'b1
`define OTX_PULL_RESET_N 1'b1

`endif

// ### verilog/otx_pkg.sv
// types shared by the optical transmit control block
// assumes: compiled before the design module
`default_nettype none

package otx_pkg;
  `include "otx_consts.svh"

  typedef enum logic [1:0] {
    OTX_TX_OFF,
    OTX_TX_RUN,
    OTX_TX_FAULT
  } otx_tx_state_type;

  typedef logic [1:0] otx_resp_type;
  localparam otx_resp_type OTX_RESP_OKAY   = 2'h0;
  localparam otx_resp_type OTX_RESP_SLVERR = 2'h2;

  typedef logic [`OTX_ADDR_W-1:0] otx_addr_type;
  typedef logic [31:0]            otx_data_type;
endpackage : otx_pkg

`default_nettype wire

// ### verilog/otx_ctrl.sv
// transmit laser gating, latched fault, receive signal-detect and squelch
// assumes: all pin inputs synchronous to i_clk; AXI4-Lite register slave
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`default_nettype none
`include "otx_consts.svh"

module otx_ctrl #(
  parameter int LANES = `OTX_LANES
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // register bus
  input  wire otx_pkg::otx_addr_type i_awaddr,
  input  wire logic                 i_awvalid,
  output logic                      o_awready,
  input  wire otx_pkg::otx_data_type i_wdata,
  input  wire logic [3:0]           i_wstrb,
  input  wire logic                 i_wvalid,
  output logic                      o_wready,
  output otx_pkg::otx_resp_type     o_bresp,
  output logic                      o_bvalid,
  input  wire logic                 i_bready,
  input  wire otx_pkg::otx_addr_type i_araddr,
  input  wire logic                 i_arvalid,
  output logic                      o_arready,
  output otx_pkg::otx_data_type     o_rdata,
  output otx_pkg::otx_resp_type     o_rresp,
  output logic                      o_rvalid,
  input  wire logic                 i_rready,
  // host control pins, each with a flag telling whether the host drives it
  input  wire logic                 i_laser_disable_in,
  input  wire logic                 i_laser_disable_drv,
  input  wire logic                 i_tx_enable,
  input  wire logic                 i_tx_enable_drv,
  input  wire logic                 i_tx_reset_n,
  input  wire logic                 i_tx_reset_drv,
  // fault causes from the laser driver
  input  wire logic [LANES-1:0]     i_overcurrent,
  input  wire logic                 i_over_temp,
  input  wire logic                 i_cal_corrupt,
  // receive side
  input  wire logic [LANES-1:0]     i_rx_light_ok,
  input  wire logic [LANES-1:0]     i_rx_data,
  // outputs
  output logic [LANES-1:0]          o_laser_on,
  output logic                      o_tx_fault_n,
  output logic                      o_rx_signal_present,
  output logic [LANES-1:0]          o_rx_data,
  output logic                      o_irq
);
  import otx_pkg::*;

  otx_tx_state_type   tx_state_q;
  otx_tx_state_type   tx_state_d;
  logic               dis_eff;
  logic               en_eff;
  logic               rst_n_eff;
  logic               fault_cause;
  logic               gates_ok;
  logic               fault_clear;
  logic [1:0]         ctrl_q;
  logic [`OTX_EV_W-1:0] event_q;
  logic [`OTX_EV_W-1:0] mask_q;
  logic [`OTX_EV_W-1:0] event_set;
  logic               sig_now;
  logic               awready_q;
  logic               wready_q;
  logic               bvalid_q;
  otx_resp_type       bresp_q;
  logic               arready_q;
  logic               rvalid_q;
  otx_resp_type       rresp_q;
  otx_data_type       rdata_q;
  otx_addr_type       awaddr_q;
  otx_data_type       wdata_q;
  logic [3:0]         wstrb_q;
  logic               wr_fire;
  logic               rd_fire;
  logic               rd_event;
  logic               sw_clear_q;
  logic [LANES-1:0]   laser_q;
  logic               fault_n_q;
  logic               sig_q;
  logic [LANES-1:0]   rxd_q;
  logic               irq_q;

  function automatic logic addr_known(input otx_addr_type a);
    addr_known = (a == `OTX_OFF_CTRL) || (a == `OTX_OFF_STATUS) ||
                 (a == `OTX_OFF_EVENT) || (a == `OTX_OFF_MASK);
  endfunction : addr_known

  // an undriven pin reads its pull level
  assign dis_eff   = i_laser_disable_drv ? i_laser_disable_in : `OTX_PULL_DISABLE; // R3
  assign en_eff    = i_tx_enable_drv ? i_tx_enable : `OTX_PULL_ENABLE; // R3
  assign rst_n_eff = i_tx_reset_drv ? i_tx_reset_n : `OTX_PULL_RESET_N; // R3

  assign fault_cause = (|i_overcurrent) | i_over_temp | i_cal_corrupt; // R4
  assign gates_ok    = en_eff & ~dis_eff & rst_n_eff & ~ctrl_q[`OTX_CTRL_LASER_OFF]; // R1 R2 R12
  // pin reset, an enable cycle or its complement, or software clears the latch
  assign fault_clear = ~rst_n_eff | ~en_eff | dis_eff | sw_clear_q; // R7 R11
  assign sig_now     = &i_rx_light_ok; // R8 R9

  always_comb begin
    tx_state_d = tx_state_q;
    case (tx_state_q)
      OTX_TX_OFF: begin
        if (gates_ok) begin
          tx_state_d = OTX_TX_RUN;
        end
      end
      OTX_TX_RUN: begin
        if (!gates_ok) begin
          tx_state_d = OTX_TX_OFF;
        end
      end
      OTX_TX_FAULT: begin
        if (fault_clear) begin
          tx_state_d = OTX_TX_OFF; // R6 R7 R11
        end
      end
      default: begin
        tx_state_d = OTX_TX_OFF;
      end
    endcase
    // a live cause beats any clear, so a fault is never lost
    if (fault_cause) begin
      tx_state_d = OTX_TX_FAULT; // R4 R6
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_state_q <= OTX_TX_OFF;
    end else begin
      tx_state_q <= tx_state_d;
    end
  end

  // laser drive and fault pin, registered so the pins never glitch
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      laser_q   <= '0;
      fault_n_q <= 1'b1;
    end else begin
      laser_q   <= {LANES{tx_state_d == OTX_TX_RUN}}; // R12 R1 R2 R6 R7
      fault_n_q <= (tx_state_d != OTX_TX_FAULT); // R5
    end
  end

  // receive status and squelch share one flop stage so they stay aligned
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sig_q <= 1'b0;
      rxd_q <= '0;
    end else begin
      sig_q <= sig_now; // R8 R9
      rxd_q <= sig_now ? i_rx_data : '0; // R10
    end
  end

  // write channel: address and data taken in either order
  assign wr_fire = !awready_q && !wready_q && !bvalid_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= OTX_RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      if (awready_q && i_awvalid) begin
        awready_q <= 1'b0;
        awaddr_q  <= i_awaddr;
      end
      if (wready_q && i_wvalid) begin
        wready_q <= 1'b0;
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= addr_known(awaddr_q) ? OTX_RESP_OKAY : OTX_RESP_SLVERR;
      end
      if (bvalid_q && i_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // control and mask registers; fault clear is a self-clearing write bit
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q     <= `OTX_CTRL_RST;
      mask_q     <= `OTX_MASK_RST;
      sw_clear_q <= 1'b0;
    end else begin
      sw_clear_q <= 1'b0;
      if (wr_fire && wstrb_q[0]) begin
        if (awaddr_q == `OTX_OFF_CTRL) begin
          ctrl_q[`OTX_CTRL_LASER_OFF] <= wdata_q[`OTX_CTRL_LASER_OFF];
          sw_clear_q                  <= wdata_q[`OTX_CTRL_FAULT_CLR];
        end
        if (awaddr_q == `OTX_OFF_MASK) begin
          mask_q <= wdata_q[`OTX_EV_W-1:0];
        end
      end
    end
  end

  // read channel: one word answered the cycle after the address is taken
  assign rd_fire  = arready_q && i_arvalid;
  assign rd_event = rd_fire && (i_araddr == `OTX_OFF_EVENT);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= OTX_RESP_OKAY;
      rdata_q   <= '0;
    end else begin
      if (rd_fire) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rresp_q   <= addr_known(i_araddr) ? OTX_RESP_OKAY : OTX_RESP_SLVERR;
        rdata_q   <= '0;
        case (i_araddr)
          `OTX_OFF_CTRL: begin
            rdata_q[1:0] <= ctrl_q;
          end
          `OTX_OFF_STATUS: begin
            rdata_q[0]   <= ~fault_n_q;
            rdata_q[1]   <= sig_q;
            rdata_q[2]   <= |laser_q;
            rdata_q[3]   <= en_eff;
            rdata_q[4]   <= dis_eff;
            rdata_q[5]   <= rst_n_eff;
            rdata_q[6]   <= |i_overcurrent;
            rdata_q[7]   <= i_over_temp;
            rdata_q[8]   <= i_cal_corrupt;
          end
          `OTX_OFF_EVENT: begin
            rdata_q[`OTX_EV_W-1:0] <= event_q;
          end
          `OTX_OFF_MASK: begin
            rdata_q[`OTX_EV_W-1:0] <= mask_q;
          end
          default: begin
            rdata_q <= '0;
          end
        endcase
      end else if (rvalid_q && i_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // sticky events: fault latched, signal lost, signal regained
  assign event_set[`OTX_EV_FAULT] = (tx_state_d == OTX_TX_FAULT) && (tx_state_q != OTX_TX_FAULT);
  assign event_set[`OTX_EV_LOS]   = sig_q && !sig_now;
  assign event_set[`OTX_EV_GAIN]  = !sig_q && sig_now;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      event_q <= '0;
      irq_q   <= 1'b0;
    end else begin
      // a set in the clearing cycle wins
      event_q <= (rd_event ? '0 : event_q) | event_set;
      irq_q   <= |(((rd_event ? '0 : event_q) | event_set) & mask_q);
    end
  end

  assign o_awready           = awready_q;
  assign o_wready            = wready_q;
  assign o_bvalid            = bvalid_q;
  assign o_bresp             = bresp_q;
  assign o_arready           = arready_q;
  assign o_rvalid            = rvalid_q;
  assign o_rresp             = rresp_q;
  assign o_rdata             = rdata_q;
  assign o_laser_on          = laser_q;
  assign o_tx_fault_n        = fault_n_q;
  assign o_rx_signal_present = sig_q;
  assign o_rx_data           = rxd_q;
  assign o_irq               = irq_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  disable_off_a: assert property (dis_eff |=> laser_q == '0) // R1
    else $error("laser on while disable high");
  enable_gate_a: assert property (!en_eff |=> laser_q == '0) // R2
    else $error("laser on while enable low");
  pull_level_a: assert property (!i_laser_disable_drv && !i_tx_enable_drv && !i_tx_reset_drv // R3
      && !fault_cause && !ctrl_q[0] && tx_state_q == OTX_TX_OFF |=> laser_q == '1)
    else $error("undriven pins did not allow transmission");
  cause_fault_a: assert property (fault_cause |=> !fault_n_q && laser_q == '0) // R4
    else $error("fault cause not reported");
  fault_pin_a: assert property (tx_state_q == OTX_TX_FAULT |-> !fault_n_q) // R5
    else $error("fault output high during fault");
  fault_hold_a: assert property (tx_state_q == OTX_TX_FAULT && !fault_clear // R6
      |=> tx_state_q == OTX_TX_FAULT && laser_q == '0)
    else $error("fault released without clear");
  reset_clear_a: assert property (!rst_n_eff && !fault_cause // R7
      |=> fault_n_q && laser_q == '0)
    else $error("reset input did not clear and hold off");
  sig_detect_a: assert property (sig_now |=> sig_q) // R8
    else $error("signal present not raised");
  sig_loss_a: assert property (!sig_now |=> !sig_q && rxd_q == '0) // R9
    else $error("signal present high with a dark lane");
  squelch_a: assert property (!sig_q |-> rxd_q == '0) // R10
    else $error("data not squelched");
  enable_cycle_a: assert property (tx_state_q == OTX_TX_FAULT && !en_eff && !fault_cause // R11
      |=> fault_n_q ##1 (fault_n_q || $past(fault_cause)))
    else $error("enable cycle did not clear fault");
  emit_gate_a: assert property (laser_q != '0 |-> $past(gates_ok) && fault_n_q) // R12
    else $error("laser on with a gate failing");
  irq_level_a: assert property ((event_q & mask_q) != '0 && !rd_event |=> irq_q)
    else $error("interrupt missing");

  fault_seen_c: cover property (tx_state_q == OTX_TX_RUN ##1 tx_state_q == OTX_TX_FAULT);
  enable_recover_c: cover property (tx_state_q == OTX_TX_FAULT ##[1:20] laser_q == '1);
  los_squelch_c: cover property (sig_q ##1 !sig_q);
  bad_addr_c: cover property (bvalid_q && bresp_q == OTX_RESP_SLVERR);
endmodule : otx_ctrl

`default_nettype wire

// ### testbench/otx_host.sv
// host board model that drives the three transmit control pins
// assumes: bench changes its requests just after a rising edge of i_clk
`default_nettype none

module otx_host (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_lvl,
  input  wire logic [2:0] i_flt,
  input  wire logic       i_clr,
  input  wire logic [1:0] i_mode,
  output logic      [2:0] o_pin,
  output logic      [2:0] o_drv
);
  logic [1:0] cnt_q;
  logic [1:0] mode_q;
  logic [2:0] hit;

  // a fault clear holds the chosen pin at its stopping level for two cycles
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q  <= 2'h0;
      mode_q <= 2'h0;
    end else if (i_clr) begin
      cnt_q  <= 2'h2;
      mode_q <= i_mode;
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end

  // bit 0 disable, 1 enable, 2 reset_n; a released pin shows the level opposite its pull
  always_comb begin
    hit   = (cnt_q != 2'h0) ? (3'h1 << mode_q) : 3'h0;
    o_drv = ~i_flt | hit;
    o_pin = ((hit | i_flt) & 3'h1) | (~(hit | i_flt) & i_lvl);
  end
endmodule : otx_host

`default_nettype wire

// ### testbench/otx_ctrl_tb.sv
// self-checking bench for otx_ctrl, host pins from otx_host
// assumes: otx_pkg, otx_ctrl and otx_host compiled first
`default_nettype none

module otx_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import otx_pkg::*;
  logic         i_clk = 1'h0, i_rst = 1'h1, clr = 1'h0;
  otx_addr_type i_awaddr = '0, i_araddr = '0;
  otx_data_type i_wdata = '0, o_rdata, rd;
  logic [3:0]   i_wstrb = 4'hF, i_overcurrent = '0, i_rx_light_ok = '0, i_rx_data = '0;
  logic         i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
  logic         i_arvalid = 1'h0, i_rready = 1'h0, i_over_temp = 1'h0, i_cal_corrupt = 1'h0;
  logic         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  otx_resp_type o_bresp, o_rresp, rs;
  logic [3:0]   o_laser_on, o_rx_data, d_e = 4'h0;
  logic         o_tx_fault_n, o_rx_signal_present, sp_e = 1'h0;
  logic [2:0]   lvl = 3'h6, flt = 3'h0, pin, drv, e;
  logic [1:0]   mode = 2'h0;
  int           miscompares = 0, check_count = 0;

  otx_ctrl i_dut (.i_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
    .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_laser_disable_in(pin[0]),
    .i_laser_disable_drv(drv[0]), .i_tx_enable(pin[1]), .i_tx_enable_drv(drv[1]),
    .i_tx_reset_n(pin[2]), .i_tx_reset_drv(drv[2]), .i_overcurrent, .i_over_temp,
    .i_cal_corrupt, .i_rx_light_ok, .i_rx_data, .o_laser_on, .o_tx_fault_n,
    .o_rx_signal_present, .o_rx_data, .o_irq);
  otx_host i_host (.i_clk, .i_rst, .i_lvl(lvl), .i_flt(flt), .i_clr(clr), .i_mode(mode),
    .o_pin(pin), .o_drv(drv));

  always #25 i_clk = ~i_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic wr(input otx_addr_type a, input otx_data_type d, input logic [3:0] s = 4'hF);
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= s;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    do begin
      @(posedge i_clk);
      if (o_awready === 1'h1) i_awvalid <= 1'h0;
      if (o_wready === 1'h1) i_wvalid <= 1'h0;
    end while (o_bvalid !== 1'h1);
    // the response stands with bvalid, so take it at the handshake edge
    rs = o_bresp;
    i_bready <= 1'h0;
  endtask : wr

  task automatic rdr(input otx_addr_type a);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do begin
      @(posedge i_clk);
      if (o_arready === 1'h1) i_arvalid <= 1'h0;
    end while (o_rvalid !== 1'h1);
    rd = o_rdata;
    rs = o_rresp;
    i_rready <= 1'h0;
  endtask : rdr

  // effective pin levels once the pulls are applied to undriven pins
  function automatic logic [2:0] eff(input logic [2:0] l, input logic [2:0] f);
    return (l & ~f) | (3'h6 & f);
  endfunction : eff

  initial begin
    void'($urandom(55280));
    repeat (8) @(posedge i_clk);
    chk(o_laser_on, 4'h0);
    chk(o_tx_fault_n, 1'h1);
    i_rst <= 1'h0;
    for (int i = 0; i < 48; i++) begin
      @(posedge i_clk);
      lvl <= 3'($urandom);
      flt <= 3'($urandom);
      repeat (3) @(posedge i_clk);
      e = eff(lvl, flt);
      chk(o_laser_on, {4{e[1] & ~e[0] & e[2]}});
      rdr(4'h4);
      chk(rd[5:3], {e[2], e[0], e[1]});
    end
    lvl <= 3'h6;
    flt <= 3'h0;
    wr(4'h0, 32'h1);
    chk(rs, OTX_RESP_OKAY);
    repeat (2) @(posedge i_clk);
    chk(o_laser_on, 4'h0);
    wr(4'h0, 32'h0, 4'h0);
    rdr(4'h0);
    chk(rd, 32'h1);
    wr(4'h0, 32'h0);
    wr(4'hC, 32'h1);
    rdr(4'h2);
    chk(rs, OTX_RESP_SLVERR);
    chk(rd, 32'h0);
    // an unmapped write must be refused and must not touch the laser gating
    wr(4'h6, 32'h1);
    chk(rs, OTX_RESP_SLVERR);
    for (int c = 0; c < 6; c++) begin
      if (c == 5) wr(4'hC, 32'h0);
      repeat (3) @(posedge i_clk);
      chk(o_laser_on, 4'hF);
      i_overcurrent <= (c < 4) ? 4'(1 << c) : 4'h0;
      i_over_temp <= (c == 4);
      i_cal_corrupt <= (c == 5);
      repeat (2) @(posedge i_clk);
      chk(o_tx_fault_n, 1'h0);
      chk(o_laser_on, 4'h0);
      chk(o_irq, c < 5);
      i_overcurrent <= 4'h0;
      i_over_temp <= 1'h0;
      i_cal_corrupt <= 1'h0;
      repeat (4) @(posedge i_clk);
      chk(o_tx_fault_n, 1'h0);
      rdr(4'h8);
      chk(rd[0], 1'h1);
      if (c % 4 == 3) wr(4'h0, 32'h2);
      else begin
        @(posedge i_clk);
        mode <= 2'(c % 4);
        clr <= 1'h1;
        @(posedge i_clk);
        clr <= 1'h0;
      end
      repeat (6) @(posedge i_clk);
      chk(o_tx_fault_n, 1'h1);
      chk(o_laser_on, 4'hF);
      chk(o_irq, 1'h0);
    end
    for (int i = 0; i < 60; i++) begin
      @(posedge i_clk);
      i_rx_light_ok <= ($urandom % 2) ? 4'hF : 4'($urandom);
      i_rx_data <= 4'($urandom);
      #1;
      chk(o_rx_signal_present, sp_e);
      chk(o_rx_data, d_e);
      sp_e = &i_rx_light_ok;
      d_e = sp_e ? i_rx_data : 4'h0;
    end
    give_verdict();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    give_verdict();
  end
endmodule : otx_ctrl_tb

`default_nettype wire
